/* File: shared/bsi_pkg.sv */
// Purpose: shared constants and types of the boundary-scan instruction logic
// Assumes: 3-bit instruction register, 132-cell boundary register
// Notes: cell positions and control-cell sharing live here as constant functions

`default_nettype none

package bsi_pkg;

  // ------------------------------------------------------------
  // instruction register
  // ------------------------------------------------------------
  localparam int IR_W = 3;
  localparam logic [2:0] IR_RESET = 3'h7;      // preset pattern, decodes as bypass
  localparam logic [1:0] IR_CAPTURE_LOW = 2'h1; // fixed low bits loaded in capture-IR
  localparam int IR_LOSS_BIT = 2;
  localparam logic [2:0] INSTR_EXTERNAL = 3'h0;
  localparam logic [2:0] INSTR_SAMPLE = 3'h1;
  localparam logic [2:0] INSTR_OUTPUTS_OFF = 3'h4;
  localparam logic [2:0] INSTR_BYPASS_ALT = 3'h5;
  localparam int IR_MID_BIT = 1;               // X1X decodes as bypass

  // ------------------------------------------------------------
  // boundary register layout
  // ------------------------------------------------------------
  localparam int BSR_LEN = 132;
  localparam logic [7:0] CTL_NONE = 8'hFF;     // input pin or control cell itself
  localparam logic [7:0] CTL_ALWAYS = 8'hFE;   // two-state output, no control cell
  localparam logic [7:0] ADDR_BUS_DIR_CTL = 8'h53;
  localparam logic [7:0] BUS_ERR_DIR_CTL = 8'h54;
  localparam logic [7:0] DATA_BUS_DIR_CTL = 8'h55;

  // tap controller states
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PAUSE_DR,
    TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR,
    TAP_PAUSE_IR, TAP_EX2_IR, TAP_UPD_IR
  } bsi_tap_t;

  // the three test pins travel together through the synchroniser
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } bsi_pins_t;

  // control cell that sets direction or drive for a given cell position
  function automatic logic [7:0] bsi_ctl_of(input int b);
    if (b <= 26 || b == 102 || (b >= 105 && b <= 110)) begin
      return ADDR_BUS_DIR_CTL;
    end
    if (b >= 67 && b <= 82) begin
      return DATA_BUS_DIR_CTL;
    end
    if (b == 103 || b == 104 || b == 114) begin
      return BUS_ERR_DIR_CTL;
    end
    if (b == 28 || b == 121 || b == 124 || b == 129 || (b >= 51 && b <= 65 && b % 2 == 1)
        || (b >= 86 && b <= 100 && b % 2 == 0)) begin
      return 8'(b + 1);
    end
    if (b inside {32, 33, 35, 36, 38, 39, 44, 45, 48, 49, 112, 115, 117, 119, 123, 127}) begin
      return CTL_ALWAYS;
    end
    return CTL_NONE;
  endfunction : bsi_ctl_of

  // active-high control cells; every other control cell is active low
  function automatic logic bsi_ctl_high(input logic [7:0] c);
    return (c == ADDR_BUS_DIR_CTL) || (c == DATA_BUS_DIR_CTL);
  endfunction : bsi_ctl_high

endpackage : bsi_pkg

`default_nettype wire

/* File: design/bsi_chain.sv */
// Purpose: boundary register, shift stage plus update latch per cell
// Assumes: enables are single-cycle strobes derived from test clock edges
// Notes: cell 0 sits next to TDO; TDI enters at the top cell

`default_nettype none
`timescale 1ns/1ps

module bsi_chain #(
  parameter int N = bsi_pkg::BSR_LEN
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic cap_en_i,
  input wire logic shift_en_i,
  input wire logic upd_en_i,
  input wire logic tdi_i,
  input wire logic [N-1:0] cap_i,
  output logic [N-1:0] sh_o,
  output logic [N-1:0] upd_o
);
  import bsi_pkg::*;

  logic [N-1:0] next_sh;

  // ------------------------------------------------------------
  // per-cell next value: capture, shift or hold
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_cell
      if (g == N - 1) begin : g_top
        assign next_sh[g] = cap_en_i ? cap_i[g] : (shift_en_i ? tdi_i : sh_o[g]);
      end else begin : g_mid
        assign next_sh[g] = cap_en_i ? cap_i[g] : (shift_en_i ? sh_o[g+1] : sh_o[g]);
      end
    end
  endgenerate

  // shift stage; update latch keeps pins steady while shifting
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sh_o <= '0;
      upd_o <= '0;
    end else begin
      sh_o <= next_sh;
      if (upd_en_i) begin
        upd_o <= sh_o;
      end
    end
  end

endmodule : bsi_chain

`default_nettype wire

/* File: design/bsi_top.sv */
// Purpose: tap controller, instruction register, decode, bypass and pin muxing
// Assumes: test pins are asynchronous and oversampled by sys_clk_i (>= 4x tck)
// Notes: tdo changes on the falling test clock edge, as a test controller expects

`default_nettype none
`timescale 1ns/1ps

// Function
// - three-bit instruction register, shift plus latches
// - latches load only in update-IR
// - test-logic-reset presets latches to all ones
// - four instructions; 000 is external test
// - capture-IR loads loss flag and 01
// - capture-IR leaves latches untouched
// - crystal mode: flag high without clock
// - external clock mode: flag always zero
// - external test selects 132-bit register
// - external test holds core in reset
// - external test drives, captures, steers pins
// - only mandatory three plus outputs-off
// - active-high control enables on one
// - active-low control enables on zero
// - many data cells share one control
// - 001 sample, X1X/101 bypass, 100 off
// - bypass captures zero in capture-DR
// - outputs-off disables all drivers, selects bypass
// - sample snapshots pins, normal operation continues
module bsi_top (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic xtal_mode_i,
  input wire logic clk_detect_i,
  input wire logic [bsi_pkg::BSR_LEN-1:0] core_out_i,
  input wire logic [bsi_pkg::BSR_LEN-1:0] core_oe_i,
  input wire logic [bsi_pkg::BSR_LEN-1:0] pin_in_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  output logic sys_reset_o,
  output logic [bsi_pkg::BSR_LEN-1:0] pin_o,
  output logic [bsi_pkg::BSR_LEN-1:0] pin_oe_o
);
  import bsi_pkg::*;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  bsi_pins_t sy1, sy2;
  logic tck_d;
  logic [BSR_LEN-1:0] pin_s1, pin_s2;

  // two flops per pin; only the second stage is read
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sy1 <= '0;
      sy2 <= '0;
      tck_d <= 1'b0;
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else begin
      sy1 <= '{tck: tck_i, tms: tms_i, tdi: tdi_i};
      sy2 <= sy1;
      tck_d <= sy2.tck;
      pin_s1 <= pin_in_i;
      pin_s2 <= pin_s1;
    end
  end

  wire tck_rise = sy2.tck & ~tck_d;
  wire tck_fall = ~sy2.tck & tck_d;

  // ------------------------------------------------------------
  // tap controller
  // ------------------------------------------------------------
  bsi_tap_t st, next_st;

  always_comb begin
    next_st = st;
    case (st)
      TAP_RESET: next_st = sy2.tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: next_st = sy2.tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: next_st = sy2.tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: next_st = sy2.tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR: next_st = sy2.tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: next_st = sy2.tms ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: next_st = sy2.tms ? TAP_EX2_DR : TAP_PAUSE_DR;
      TAP_EX2_DR: next_st = sy2.tms ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: next_st = sy2.tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: next_st = sy2.tms ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: next_st = sy2.tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR: next_st = sy2.tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: next_st = sy2.tms ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: next_st = sy2.tms ? TAP_EX2_IR : TAP_PAUSE_IR;
      TAP_EX2_IR: next_st = sy2.tms ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: next_st = sy2.tms ? TAP_SEL_DR : TAP_IDLE;
      default: next_st = TAP_RESET;
    endcase
  end

  // state moves on the rising test clock edge only
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st <= TAP_RESET;
    end else if (tck_rise) begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // crystal-loss status and instruction register
  // ------------------------------------------------------------
  logic crystal_loss_flag;
  logic [IR_W-1:0] ir_sh, ir;

  // external clock mode never reports a loss
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      crystal_loss_flag <= 1'b0;
    end else begin
      crystal_loss_flag <= xtal_mode_i & ~clk_detect_i;
    end
  end

  // shift stage captures on rise, latches load on fall in update-IR
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ir_sh <= IR_RESET;
      ir <= IR_RESET;
    end else begin
      if (tck_rise && st == TAP_CAP_IR) begin
        ir_sh <= {crystal_loss_flag, IR_CAPTURE_LOW};
      end else if (tck_rise && st == TAP_SH_IR) begin
        ir_sh <= {sy2.tdi, ir_sh[IR_W-1:1]};
      end
      if (st == TAP_RESET) begin
        ir <= IR_RESET;
      end else if (tck_fall && st == TAP_UPD_IR) begin
        ir <= ir_sh;
      end
    end
  end

  // ------------------------------------------------------------
  // instruction decode; unlisted optional codes fall to bypass
  // ------------------------------------------------------------
  wire is_external = (ir == INSTR_EXTERNAL);
  wire is_sample = (ir == INSTR_SAMPLE);
  wire is_off = (ir == INSTR_OUTPUTS_OFF);
  wire is_bypass = ir[IR_MID_BIT] | (ir == INSTR_BYPASS_ALT);
  wire bsr_sel = is_external | is_sample;

  // ------------------------------------------------------------
  // boundary register and bypass stage
  // ------------------------------------------------------------
  logic [BSR_LEN-1:0] bsr_sh, bsr_upd;
  logic bypass_q;
  wire dr_cap = tck_rise && st == TAP_CAP_DR;
  wire dr_shift = tck_rise && st == TAP_SH_DR;

  bsi_chain #(.N(BSR_LEN)) u_chain (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .cap_en_i(dr_cap & bsr_sel),
    .shift_en_i(dr_shift & bsr_sel),
    .upd_en_i(tck_fall && st == TAP_UPD_DR && bsr_sel),
    .tdi_i(sy2.tdi),
    .cap_i(pin_s2),
    .sh_o(bsr_sh),
    .upd_o(bsr_upd)
  );

  // bypass shows zero first after capture
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      bypass_q <= 1'b0;
    end else if (dr_cap && !bsr_sel) begin
      bypass_q <= 1'b0;
    end else if (dr_shift && !bsr_sel) begin
      bypass_q <= sy2.tdi;
    end
  end

  // ------------------------------------------------------------
  // pin drive under test; one control cell steers a whole group
  // ------------------------------------------------------------
  logic [BSR_LEN-1:0] ext_oe, next_pin, next_oe;

  genvar g;
  generate
    for (g = 0; g < BSR_LEN; g++) begin : g_pin
      localparam logic [7:0] C = bsi_ctl_of(g);
      if (C == CTL_NONE) begin : g_in
        assign ext_oe[g] = 1'b0;
      end else if (C == CTL_ALWAYS) begin : g_out
        assign ext_oe[g] = 1'b1;
      end else if (bsi_ctl_high(C)) begin : g_hi
        assign ext_oe[g] = bsr_upd[C];
      end else begin : g_lo
        assign ext_oe[g] = ~bsr_upd[C];
      end
    end
  endgenerate

  // sample keeps the core in charge of the pins
  assign next_pin = is_external ? bsr_upd : core_out_i;
  assign next_oe = is_off ? '0 : (is_external ? ext_oe : core_oe_i);

  // tdo source muxing; a register keeps the pin glitch free
  wire tdo_src = (st == TAP_SH_IR) ? ir_sh[0] : (bsr_sel ? bsr_sh[0] : bypass_q);
  wire shifting = (st == TAP_SH_IR) || (st == TAP_SH_DR);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      tdo_o <= 1'b0;
      tdo_oe_o <= 1'b0;
      sys_reset_o <= 1'b0;
      pin_o <= '0;
      pin_oe_o <= '0;
    end else begin
      if (tck_fall) begin
        tdo_o <= tdo_src;
        tdo_oe_o <= shifting;
      end
      sys_reset_o <= is_external;
      pin_o <= next_pin;
      pin_oe_o <= next_oe;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  a_ir_reset_preset: assert property (st == TAP_RESET |=> ir == IR_RESET)
    else $error("latches not preset in reset state");
  a_ir_update_only: assert property (ir != $past(ir) |->
    ($past(st) == TAP_UPD_IR || $past(st) == TAP_RESET))
    else $error("instruction changed outside update");
  a_ir_capture_val: assert property (tck_rise && st == TAP_CAP_IR |=>
    ir_sh == {$past(crystal_loss_flag), IR_CAPTURE_LOW} && $stable(ir))
    else $error("capture-IR value wrong");
  a_loss_ext_zero: assert property (!xtal_mode_i |=> !crystal_loss_flag)
    else $error("loss flag set in external clock mode");
  a_loss_no_clock: assert property (xtal_mode_i && !clk_detect_i |=> crystal_loss_flag)
    else $error("loss flag missing");
  a_ext_core_reset: assert property (is_external |=> sys_reset_o)
    else $error("core not held in reset under external test");
  a_off_no_drive: assert property (is_off |=> pin_oe_o == '0)
    else $error("driver enabled under outputs-off");
  a_bypass_zero: assert property (dr_cap && !bsr_sel |=> !bypass_q)
    else $error("bypass stage did not capture zero");
  a_sample_normal: assert property (is_sample |=> pin_o == $past(core_out_i))
    else $error("sample disturbed pin data");
  a_ext_drive: assert property (is_external |=> pin_o == $past(bsr_upd))
    else $error("external test not driving scanned data");
  a_addr_group: assert property (is_external |=>
    pin_oe_o[0] == $past(bsr_upd[ADDR_BUS_DIR_CTL]))
    else $error("active-high control not honoured");

  c_external: cover property (is_external ##1 sys_reset_o);
  c_off: cover property (is_off);
  c_ir_update: cover property (tck_fall && st == TAP_UPD_IR);
  c_bypass_cap: cover property (dr_cap && is_bypass);

endmodule : bsi_top

`default_nettype wire

/* File: verif/bsi_jtag_master.sv */
// Purpose: test controller model that drives the scan port
// Assumes: 4 system clocks per test clock phase, 160 ns period
// Notes: tck rests low between frames, tdi high and tms low; tms and tdi start high, as if pulled up

`default_nettype none
`timescale 1ns/1ps

module bsi_jtag_master (
  input wire logic sys_clk_i,
  input wire logic tdo_i,
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o
);
  import bsi_pkg::*;

  // ------------------------------------------------------------
  // idle levels
  // ------------------------------------------------------------
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end

  // ------------------------------------------------------------
  // frame tasks
  // ------------------------------------------------------------
  // one test clock; tdo read as tck falls, before the device replaces it
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    tms_o = tms;
    tdi_o = tdi;
    repeat (4) @(negedge sys_clk_i);
    tck_o = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    tdo = tdo_i;
    tck_o = 1'b0;
  endtask : step

  // from idle through capture, n shifts, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [BSR_LEN-1:0] din,
                      output logic [BSR_LEN-1:0] dout);
    logic t;
    dout = '0;
    step(1'b1, 1'b1, t);
    if (ir) step(1'b1, 1'b1, t);
    step(1'b0, 1'b1, t); // capture state
    step(1'b0, 1'b1, t); // into shift state
    for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
    step(1'b1, 1'b1, t); // update state
    step(1'b0, 1'b1, t); // idle
  endtask : scan

  task automatic load_ir(input logic [IR_W-1:0] code, output logic [IR_W-1:0] cap);
    logic [BSR_LEN-1:0] d;
    scan(1'b1, IR_W, BSR_LEN'(code), d);
    cap = d[IR_W-1:0];
  endtask : load_ir

  task automatic scan_dr(input logic [BSR_LEN-1:0] din, output logic [BSR_LEN-1:0] dout);
    scan(1'b0, BSR_LEN, din, dout);
  endtask : scan_dr

  // five tms highs reach test-logic-reset, then one low to idle
  task automatic reset_tap;
    logic t;
    repeat (5) step(1'b1, 1'b1, t);
    step(1'b0, 1'b1, t);
  endtask : reset_tap
endmodule : bsi_jtag_master

`default_nettype wire

/* File: verif/bsi_top_tb.sv */
// Purpose: self-checking bench of the boundary-scan instruction logic
// Assumes: controller model drives tck, tms and tdi
// Notes: control-cell expectations are spot checks, not the whole map

`default_nettype none
`timescale 1ns/1ps

module bsi_top_tb;
  import bsi_pkg::*;

  logic sys_clk, rst, tck, tms, tdi, tdo, tdo_oe, xtal_mode, clk_detect, sys_reset;
  logic [BSR_LEN-1:0] core_out, core_oe, pin_in, pin, pin_oe, so, d;
  logic [2:0] cap;
  int errors, n_tests;

  bsi_top bsi_top_i (
    .sys_clk_i(sys_clk), .rst_i(rst), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .xtal_mode_i(xtal_mode), .clk_detect_i(clk_detect), .core_out_i(core_out),
    .core_oe_i(core_oe), .pin_in_i(pin_in), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
    .sys_reset_o(sys_reset), .pin_o(pin), .pin_oe_o(pin_oe)
  );

  bsi_jtag_master bsi_jtag_master_i (
    .sys_clk_i(sys_clk), .tdo_i(tdo), .tck_o(tck), .tms_o(tms), .tdi_o(tdi)
  );

  // ------------------------------------------------------------
  // clock, checks, verdict
  // ------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic check(input string what, input logic [BSR_LEN-1:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic test_done;
    if (errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done

  // pins follow the core whenever external test is not loaded
  task automatic check_normal(input logic [BSR_LEN-1:0] oe);
    check("pin", core_out, pin);
    check("pin_oe", oe, pin_oe);
    check("sys_reset", 1'b0, sys_reset);
  endtask : check_normal

  // spot cells: two per active-high group, an active-low pair, two-state, input, control
  task automatic check_cells(input logic [BSR_LEN-1:0] v);
    check("oe cells", {v[83], v[83], v[85], v[85], ~v[84], ~v[29], 3'b100},
      {pin_oe[0], pin_oe[26], pin_oe[70], pin_oe[82], pin_oe[103], pin_oe[28],
       pin_oe[32], pin_oe[27], pin_oe[83]});
  endtask : check_cells

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_capture;
    logic [1:0] m;
    for (int k = 0; k < 4; k++) begin
      m = 2'(k);
      xtal_mode = m[1];
      clk_detect = m[0];
      repeat (3) @(negedge sys_clk);
      bsi_jtag_master_i.load_ir(3'h7, cap);
      check("ir capture", {m[1] & ~m[0], IR_CAPTURE_LOW}, cap);
      check("tdo_oe idle", 1'b0, tdo_oe);
    end
  endtask : t_capture

  task automatic t_bypass;
    logic [2:0] codes [6] = '{3'h2, 3'h3, 3'h6, 3'h7, INSTR_BYPASS_ALT, INSTR_OUTPUTS_OFF};
    d = {33{4'h3}};
    foreach (codes[k]) begin
      bsi_jtag_master_i.load_ir(codes[k], cap);
      bsi_jtag_master_i.scan_dr(d, so);
      check("bypass out", {d[BSR_LEN-2:0], 1'b0}, so);
      check_normal(codes[k] == INSTR_OUTPUTS_OFF ? '0 : core_oe);
    end
  endtask : t_bypass

  task automatic t_sample;
    d = {33{4'h5}};
    bsi_jtag_master_i.load_ir(INSTR_SAMPLE, cap);
    check_normal(core_oe);
    bsi_jtag_master_i.scan_dr(d, so);
    check("sample out", {33{4'hC}}, so);
    check_normal(core_oe);
  endtask : t_sample

  task automatic t_extest;
    bsi_jtag_master_i.load_ir(INSTR_EXTERNAL, cap);
    check("sys_reset", 1'b1, sys_reset);
    check("pin", d, pin);
    check_cells(d);
    pin_in = {33{4'hA}};
    bsi_jtag_master_i.scan_dr(~d, so);
    check("extest out", {33{4'hA}}, so);
    check("pin", ~d, pin);
    check_cells(~d);
    check("sys_reset", 1'b1, sys_reset);
    bsi_jtag_master_i.reset_tap();
    check_normal(core_oe);
  endtask : t_extest

  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    errors = 0;
    n_tests = 0;
    rst = 1'b1;
    xtal_mode = 1'b0;
    clk_detect = 1'b1;
    core_out = {33{4'h9}};
    core_oe = {33{4'h6}};
    pin_in = {33{4'hC}};
    repeat (4) @(negedge sys_clk);
    rst = 1'b0;
    repeat (3) @(negedge sys_clk);
    check_normal(core_oe);
    // the controller leaves reset in test-logic-reset; frames start from idle
    bsi_jtag_master_i.reset_tap();
    t_capture();
    t_bypass();
    t_sample();
    t_extest();
    test_done();
  end

  // a hang counts as a mismatch
  initial begin
    repeat (60000) @(posedge sys_clk);
    errors++;
    test_done();
  end
endmodule : bsi_top_tb

`default_nettype wire
